// File: sbcd_pkg.sv
// sbcd_pkg.sv: constants and types for the store buffer and cache debug read
// How it works
// - direct access only for secure privileged code, unless without security
// - location is a physical RAM address; the RAM bank is the cache way XOR set index bit 0
// - location bit 0 clear picks the tag RAM, set picks the data RAM
// - set index from location bits 14:5, way from bit 31
// - data RAM reads take the word offset from location bits 5:1
// - direct reads ignore ECC errors and never return check bits
// - tag reads drive every bit outside a defined field to zero
// - data tag: status 25:23, valid 22, tag 21 down to a size-set bit
// - instruction tag reads: valid 21, tag 20 down to a size-dependent bit
// - status 0 clean transient, 1 clean, 2 to 6 dirty by outer attribute
// - code 7 reserved; dirty lines are never transient, carry outer type
// - five identical slots: address, up to 64 data bits, attributes
// - normal stores buffered, not coupled memory, private bus or AHB port
// - a normal store to the same doubleword merges into the waiting slot
// - no merge: device, issued slot, attribute mismatch, exclusive, release
// - cacheable stores look up the cache and write the hit line on drain
// - non-cacheable and no-allocate missing stores become AXI writes
// - allocating misses start a linefill in one of two linefill buffers
// - device order kept; stores wait for load-acquire; release needs empty
// - device stores drain before device loads; unmergeable slots go at once
// - drain on maintenance, blocked store, barrier, debug event
package sbcd_pkg;
   localparam int SB_SLOTS = 5;
   localparam int DATA_W = 64;
   localparam int STRB_W = 8;
   localparam int DW_LSB = 3;
   localparam int HOLD_CYCLES = 16;
   localparam logic [31:0] ICRR_ADDR = 32'he001e204;
   localparam logic [31:0] ICLR_ADDR = 32'he001e214;
   localparam logic [31:0] DCRR_ADDR = 32'he001e200;
   localparam logic [31:0] DCLR_ADDR = 32'he001e210;
   localparam int LOC_RAM = 0;
   localparam int LOC_WORD_LO = 1;
   localparam int LOC_WORD_HI = 5;
   localparam int LOC_IDX_LO = 5;
   localparam int LOC_IDX_HI = 14;
   localparam int LOC_WAY = 31;
   localparam logic [31:0] DC_FIELDS = 32'h03ffffff;
   localparam logic [31:0] IC_FIELDS = 32'h003fffff;
   localparam logic [2:0] ST_CLEAN_TR = 3'h0;
   localparam logic [2:0] ST_CLEAN = 3'h1;
   localparam logic [2:0] ST_DIRTY = 3'h2;
   localparam logic [2:0] ST_RSVD = 3'h7;
   localparam logic [2:0] OUT_WT_NWA = 3'h4;

   typedef struct packed {
      logic device;
      logic cacheable;
      logic wrAlloc;
      logic secure;
      logic excl;
      logic storeRel;
      logic bypass;
      logic [2:0] outer;
   } sbcd_attr_s;

   typedef struct packed {
      logic [31:0] addr;
      logic [DATA_W-1:0] data;
      logic [STRB_W-1:0] strb;
      sbcd_attr_s attr;
   } sbcd_store_s;

   typedef struct packed {
      logic [31:0] addr;
      logic [DATA_W-1:0] data;
      logic [STRB_W-1:0] strb;
      logic [2:0] status;
   } sbcd_wr_s;

   typedef struct packed {
      logic dcache;
      logic dataRam;
      logic bank;
      logic [LOC_IDX_HI-LOC_IDX_LO:0] index;
      logic [LOC_WORD_HI-LOC_WORD_LO:0] word;
   } sbcd_ram_s;

   // written lines are dirty and never transient; clamp keeps 7 unused
   function automatic logic [2:0] dirtyStatus(input logic [2:0] outer);
      return (outer > OUT_WT_NWA) ? ST_DIRTY + OUT_WT_NWA : ST_DIRTY + outer;
   endfunction
endpackage

// File: sbcd_slot_mem.sv
// sbcd_slot_mem.sv: slot data storage with byte merge and registered read
`timescale 1ns/1ps
`default_nettype none
module sbcd_slot_mem #(
   parameter int N = 5,
   parameter int W = 64
) (
   input wire logic clk,
   input wire logic wrEn,
   input wire logic [$clog2(N)-1:0] wrIdx,
   input wire logic [W-1:0] wrData,
   input wire logic [W/8-1:0] wrBe,
   input wire logic [$clog2(N)-1:0] rdIdx,
   output logic [W-1:0] rdData
);
   logic [W-1:0] mem [N];

   always_ff @(posedge clk) begin
      if (wrEn) begin
         for (int b = 0; b < W / 8; b++) begin
            if (wrBe[b]) begin
               mem[wrIdx][b*8 +: 8] <= wrData[b*8 +: 8];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      rdData <= mem[rdIdx];
   end
endmodule
`default_nettype wire

// File: sbcd_dcar.sv
// sbcd_dcar.sv: direct cache RAM read registers and tag formatting
`timescale 1ns/1ps
`default_nettype none
module sbcd_dcar
   import sbcd_pkg::*;
#(
   parameter bit SEC_EXT = 1'b1,
   parameter int DC_TAG_LSB = 0,
   parameter int IC_TAG_LSB = 0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [31:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic secure,
   input wire logic priv,
   output logic [31:0] regRdata,
   output logic regRvalid,
   output logic regErr,
   output logic ramEn,
   output var sbcd_ram_s ramReq,
   input wire logic [31:0] ramRdata
);
   localparam logic [31:0] DC_KEEP =
      DC_FIELDS & ~((32'h1 << DC_TAG_LSB) - 32'h1);
   localparam logic [31:0] IC_KEEP =
      IC_FIELDS & ~((32'h1 << IC_TAG_LSB) - 32'h1);
   logic [31:0] icLoc, dcLoc, icNext, dcNext;
   logic allowed, isIc, pend, pendIc, pendData;

   function automatic sbcd_ram_s locToReq(input logic [31:0] loc,
                                          input logic dc);
      sbcd_ram_s r;
      r.dcache = dc;
      r.dataRam = loc[LOC_RAM];
      r.index = loc[LOC_IDX_HI:LOC_IDX_LO];
      r.word = r.dataRam ? loc[LOC_WORD_HI:LOC_WORD_LO] : '0;
      // banks swap on odd sets so both ways share the read ports evenly
      r.bank = loc[LOC_WAY] ^ loc[LOC_IDX_LO];
      return r;
   endfunction

   assign allowed = !SEC_EXT || (secure && priv);
   assign icNext = (regWr && regAddr == ICLR_ADDR) ? regWdata : icLoc;
   assign dcNext = (regWr && regAddr == DCLR_ADDR) ? regWdata : dcLoc;
   assign isIc = regAddr == ICRR_ADDR;
   assign ramEn = allowed && regRd && (isIc || regAddr == DCRR_ADDR);
   assign ramReq = locToReq(isIc ? icNext : dcNext, !isIc);

   always_ff @(posedge clk) begin
      if (rst) begin
         icLoc <= '0;
         dcLoc <= '0;
      end else if (allowed) begin
         icLoc <= icNext;
         dcLoc <= dcNext;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pend <= 1'b0;
         pendIc <= 1'b0;
         pendData <= 1'b0;
         regRvalid <= 1'b0;
         regErr <= 1'b0;
         regRdata <= '0;
      end else begin
         pend <= ramEn;
         pendIc <= isIc;
         pendData <= ramReq.dataRam;
         regRvalid <= 1'b0;
         regErr <= 1'b0;
         if (pend) begin
            regRvalid <= 1'b1;
            // ecc syndrome never reaches this path, so errors pass silently
            if (pendData) begin
               regRdata <= ramRdata;
            end else begin
               regRdata <= ramRdata & (pendIc ? IC_KEEP : DC_KEEP);
            end
         end else if (regRd && !ramEn) begin
            regRvalid <= 1'b1;
            regErr <= !allowed || !(regAddr == ICLR_ADDR
                                    || regAddr == DCLR_ADDR);
            if (allowed && regAddr == ICLR_ADDR) begin
               regRdata <= icLoc;
            end else if (allowed && regAddr == DCLR_ADDR) begin
               regRdata <= dcLoc;
            end else begin
               regRdata <= '0;
            end
         end
      end
   end

   chk_deny_err: assert property (
      @(posedge clk) disable iff (rst)
      regRd && !allowed |=> regErr && regRdata == '0)
      else $error("denied access did not report an error");

   chk_rr_latency: assert property (
      @(posedge clk) disable iff (rst)
      ramEn |-> ##2 regRvalid && !regErr)
      else $error("read register answer not two cycles after request");

   chk_tag_zero: assert property (
      @(posedge clk) disable iff (rst)
      pend && !pendData && !pendIc |=> (regRdata & ~DC_KEEP) == '0)
      else $error("data tag read left undefined bits set");
endmodule
`default_nettype wire

// File: sbcd_store_buffer.sv
// sbcd_store_buffer.sv: store buffer with its drain engine and debug reads
`timescale 1ns/1ps
`default_nettype none
module sbcd_store_buffer
   import sbcd_pkg::*;
#(
   parameter int SLOTS = SB_SLOTS,
   parameter bit SEC_EXT = 1'b1,
   parameter int DC_TAG_LSB = 0,
   parameter int IC_TAG_LSB = 0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic stValid,
   output logic stReady,
   input wire sbcd_store_s st,
   output logic bypassValid,
   input wire logic bypassReady,
   input wire logic acqPending,
   input wire logic devLoadReq,
   output logic devLoadGo,
   input wire logic cmoPending,
   input wire logic barrierReq,
   input wire logic debugEvent,
   output logic sbEmpty,
   output logic lkValid,
   output logic [31:0] lkAddr,
   input wire logic lkDone,
   input wire logic lkHit,
   output logic cwValid,
   input wire logic cwReady,
   output logic awValid,
   input wire logic awReady,
   output logic lfValid,
   output logic lfSel,
   input wire logic [1:0] lfReady,
   output var sbcd_wr_s wr,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [31:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic secure,
   input wire logic priv,
   output logic [31:0] regRdata,
   output logic regRvalid,
   output logic regErr,
   output logic ramEn,
   output var sbcd_ram_s ramReq,
   input wire logic [31:0] ramRdata
);
   localparam int IW = $clog2(SLOTS);
   localparam int CW = $clog2(SLOTS + 1);
   localparam logic [7:0] HOLD_T = 8'(HOLD_CYCLES);

   typedef enum logic [2:0] {
      IDLE,
      FETCH,
      LOOKUP,
      CWR,
      AXW,
      LFL
   } sbcd_state_e;

   sbcd_state_e state;
   logic [31:0] sAddr [SLOTS];
   sbcd_attr_s sAttr [SLOTS];
   logic [STRB_W-1:0] sStrb [SLOTS];
   logic [SLOTS-1:0] sValid, sIssued, match, devSlot;
   logic [IW-1:0] head, tail, wIdx;
   logic [CW-1:0] count;
   logic [DATA_W-1:0] memData;
   logic [7:0] holdCnt;
   logic inMerge, canMerge, accept, stall, flush;
   logic issueNow, holdDone, done;
   sbcd_attr_s hAttr;

   function automatic logic [IW-1:0] nextIdx(input logic [IW-1:0] i);
      return (i == IW'(SLOTS - 1)) ? '0 : IW'(i + 1'b1);
   endfunction

   function automatic logic mergeOk(input sbcd_attr_s a);
      return !a.device && !a.excl && !a.storeRel;
   endfunction

   // slot chosen for merge must not be the one leaving this cycle
   always_comb begin
      for (int i = 0; i < SLOTS; i++) begin
         match[i] = sValid[i] && !sIssued[i]
            && !(issueNow && head == IW'(i))
            && mergeOk(sAttr[i])
            && sAddr[i][31:DW_LSB] == st.addr[31:DW_LSB]
            && sAttr[i] == st.attr;
         devSlot[i] = sValid[i] && sAttr[i].device;
      end
   end

   always_comb begin
      wIdx = tail;
      for (int i = SLOTS - 1; i >= 0; i--) begin
         if (match[i]) begin
            wIdx = IW'(i);
         end
      end
   end

   assign hAttr = sAttr[head];
   assign inMerge = mergeOk(st.attr);
   assign canMerge = inMerge && |match;
   assign sbEmpty = count == '0 && state == IDLE;
   assign bypassValid = stValid && st.attr.bypass;
   assign devLoadGo = !(|devSlot);

   always_comb begin
      if (st.attr.bypass) begin
         stReady = bypassReady;
      end else if (acqPending) begin
         stReady = 1'b0;
      end else if (st.attr.storeRel) begin
         stReady = sbEmpty;
      end else begin
         stReady = canMerge || count != CW'(SLOTS);
      end
   end

   assign accept = stValid && stReady && !st.attr.bypass;
   assign stall = stValid && !st.attr.bypass && !stReady;
   assign flush = cmoPending || barrierReq || debugEvent || stall
      || (devLoadReq && |devSlot);
   // mergeable slots linger a while to soak up neighbouring stores
   assign issueNow = state == IDLE && sValid[head]
      && (flush || holdDone || !mergeOk(hAttr));
   assign done = (state == CWR && cwReady) || (state == AXW && awReady)
      || (state == LFL && lfReady[lfSel]);

   always_ff @(posedge clk) begin
      if (rst || state != IDLE || accept || !sValid[head]) begin
         holdCnt <= '0;
      end else if (!holdDone) begin
         holdCnt <= holdCnt + 8'h01;
      end
   end

   assign holdDone = holdCnt == HOLD_T;

   always_ff @(posedge clk) begin
      if (rst) begin
         sValid <= '0;
         sIssued <= '0;
      end else begin
         if (accept) begin
            sValid[wIdx] <= 1'b1;
         end
         if (issueNow) begin
            sIssued[head] <= 1'b1;
         end
         if (done) begin
            sValid[head] <= 1'b0;
            sIssued[head] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < SLOTS; i++) begin
            sAddr[i] <= '0;
            sAttr[i] <= '0;
            sStrb[i] <= '0;
         end
      end else if (accept) begin
         sAddr[wIdx] <= st.addr;
         sAttr[wIdx] <= st.attr;
         sStrb[wIdx] <= canMerge ? (sStrb[wIdx] | st.strb) : st.strb;
      end
   end

   // strict fifo drain keeps device order for free; acquire and release order come from the stReady gating
   always_ff @(posedge clk) begin
      if (rst) begin
         head <= '0;
         tail <= '0;
         count <= '0;
      end else begin
         if (accept && !canMerge) begin
            tail <= nextIdx(tail);
         end
         if (done) begin
            head <= nextIdx(head);
         end
         count <= count + CW'(accept && !canMerge) - CW'(done);
      end
   end

   sbcd_slot_mem #(
      .N(SLOTS),
      .W(DATA_W)
   ) u_mem (
      .clk(clk),
      .wrEn(accept),
      .wrIdx(wIdx),
      .wrData(st.data),
      .wrBe(st.strb),
      .rdIdx(head),
      .rdData(memData)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= IDLE;
      end else begin
         case (state)
            IDLE: if (issueNow) begin
               state <= FETCH;
            end
            FETCH: state <= hAttr.cacheable ? LOOKUP : AXW;
            LOOKUP: if (lkDone) begin
               if (lkHit) begin
                  state <= CWR;
               end else if (hAttr.wrAlloc) begin
                  state <= LFL;
               end else begin
                  state <= AXW;
               end
            end
            CWR, AXW, LFL: if (done) begin
               state <= IDLE;
            end
            default: state <= IDLE;
         endcase
      end
   end

   // head data is stable since issue, so fetch can capture it directly
   always_ff @(posedge clk) begin
      if (rst) begin
         wr <= '0;
      end else if (state == FETCH) begin
         wr.addr <= sAddr[head];
         wr.data <= memData;
         wr.strb <= sStrb[head];
         wr.status <= dirtyStatus(hAttr.outer);
      end
   end

   assign lkValid = state == LOOKUP;
   assign lkAddr = wr.addr;
   assign cwValid = state == CWR;
   assign awValid = state == AXW;
   assign lfValid = state == LFL;
   assign lfSel = !lfReady[0];

   sbcd_dcar #(
      .SEC_EXT(SEC_EXT),
      .DC_TAG_LSB(DC_TAG_LSB),
      .IC_TAG_LSB(IC_TAG_LSB)
   ) u_dcar (
      .clk(clk),
      .rst(rst),
      .regWr(regWr),
      .regRd(regRd),
      .regAddr(regAddr),
      .regWdata(regWdata),
      .secure(secure),
      .priv(priv),
      .regRdata(regRdata),
      .regRvalid(regRvalid),
      .regErr(regErr),
      .ramEn(ramEn),
      .ramReq(ramReq),
      .ramRdata(ramRdata)
   );

   chk_acq_hold: assert property (
      @(posedge clk) disable iff (rst)
      acqPending |-> !accept)
      else $error("store taken while a load-acquire is open");

   chk_release_empty: assert property (
      @(posedge clk) disable iff (rst)
      accept && st.attr.storeRel |-> count == '0 && state == IDLE)
      else $error("release taken with stores pending");

   chk_full_stall: assert property (
      @(posedge clk) disable iff (rst)
      stValid && !st.attr.bypass && count == CW'(SLOTS) && !canMerge
      |-> !stReady)
      else $error("store taken with no free slot");

   chk_merge_count: assert property (
      @(posedge clk) disable iff (rst)
      accept && canMerge && !done |=> count == $past(count))
      else $error("merge allocated a new slot");

   chk_flush_issue: assert property (
      @(posedge clk) disable iff (rst)
      (barrierReq || cmoPending || debugEvent) && state == IDLE
      && count != '0 |=> state == FETCH)
      else $error("drain request did not issue the head slot");

   chk_dev_drain: assert property (
      @(posedge clk) disable iff (rst)
      state == IDLE && sValid[head] && hAttr.device |=> state == FETCH)
      else $error("device slot not drained at once");

   chk_nc_axi: assert property (
      @(posedge clk) disable iff (rst)
      state == FETCH && !hAttr.cacheable |=> awValid ##0 !lkValid)
      else $error("non-cacheable store did not go to AXI");

   chk_hit_write: assert property (
      @(posedge clk) disable iff (rst)
      lkValid && lkDone && lkHit |=> cwValid && !awValid && !lfValid)
      else $error("cache hit did not write the cache");

   chk_miss_fill: assert property (
      @(posedge clk) disable iff (rst)
      lkValid && lkDone && !lkHit && hAttr.wrAlloc |=> lfValid)
      else $error("allocating miss did not start a linefill");

   chk_bypass_skip: assert property (
      @(posedge clk) disable iff (rst)
      bypassValid |=> count <= $past(count))
      else $error("bypass store entered the buffer");
endmodule
`default_nettype wire

// File: sbcd_partner.sv
// sbcd_partner.sv: cache, linefill, AXI and cache RAM responder model
`timescale 1ns/1ps
`default_nettype none
module sbcd_partner
   import sbcd_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic stall,
   input wire logic hit,
   input wire logic lkValid,
   output logic lkDone,
   output logic lkHit,
   input wire logic cwValid,
   output logic cwReady,
   input wire logic awValid,
   output logic awReady,
   input wire logic lfValid,
   output logic [1:0] lfReady,
   input wire logic ramEn,
   input wire sbcd_ram_s ramReq,
   output logic [31:0] ramRdata
);
   logic late;
   logic go;
   // each answer waits a cycle, so requests must hold
   always_ff @(posedge clk) begin
      if (rst) late <= 1'b0;
      else late <= (lkValid | cwValid | awValid | lfValid) & !late;
   end
   assign go = late & !stall;
   assign lkDone = lkValid & go;
   assign lkHit = hit;
   assign cwReady = cwValid & go;
   assign awReady = awValid & go;
   assign lfReady = {lfValid & go, 1'b0};
   // word mirrors the addressed place; idle bus toggles
   always_ff @(posedge clk) begin
      if (rst) ramRdata <= 32'h0;
      else if (ramEn) ramRdata <= {14'h3fff, ramReq.dcache, ramReq.bank,
         ramReq.index, ramReq.dataRam ? ramReq.word : 5'h0, ramReq.dataRam};
      else ramRdata <= ~ramRdata;
   end
endmodule
`default_nettype wire

// File: sbcd_store_buffer_test.sv
// sbcd_store_buffer_test.sv: self-checking bench for the store buffer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, x, y) \
   begin checksDone++; if ((y) !== (x)) begin nMismatch++; \
   $display("MISMATCH %s exp %h got %h", nm, x, y); end end
module sbcd_store_buffer_test;
   import sbcd_pkg::*;
   localparam int WRW = $bits(sbcd_wr_s);
   logic clk, stReady, bypassValid, devLoadGo, sbEmpty, lkValid, lkDone;
   logic lkHit, cwValid, cwReady, awValid, awReady, lfValid, lfSel;
   logic regRvalid, regErr, ramEn;
   logic rst = 1'b1, stValid = 1'b0, acqPending = 1'b0, devLoadReq = 1'b0;
   logic cmoPending = 1'b0, barrierReq = 1'b0, debugEvent = 1'b0;
   logic regWr = 1'b0, regRd = 1'b0, secure = 1'b1, priv = 1'b1;
   logic stall = 1'b0, hit = 1'b1;
   logic [1:0] lfReady;
   logic [31:0] lkAddr, regRdata, ramRdata;
   logic [31:0] regAddr = 32'h0, regWdata = 32'h0;
   sbcd_store_s st = '0;
   sbcd_wr_s wr;
   sbcd_ram_s ramReq;
   logic [WRW+1:0] outQ[$];
   int nMismatch = 0, checksDone = 0;
   // {dcache, location, expected read word}
   logic [64:0] rows[5] = '{{1'b0, 32'h80007fe0, 32'h003cffc0},
      {1'b0, 32'h00000023, 32'hfffd0063}, {1'b1, 32'h80000040, 32'h03ff0080},
      {1'b1, 32'h0000403f, 32'hffff807f}, {1'b1, 32'h0, 32'h03fe0000}};

   sbcd_store_buffer sbcd_store_buffer_i (.clk(clk), .rst(rst),
      .stValid(stValid), .stReady(stReady), .st(st),
      .bypassValid(bypassValid), .bypassReady(1'b1),
      .acqPending(acqPending), .devLoadReq(devLoadReq),
      .devLoadGo(devLoadGo), .cmoPending(cmoPending),
      .barrierReq(barrierReq), .debugEvent(debugEvent), .sbEmpty(sbEmpty),
      .lkValid(lkValid), .lkAddr(lkAddr), .lkDone(lkDone), .lkHit(lkHit),
      .cwValid(cwValid), .cwReady(cwReady), .awValid(awValid),
      .awReady(awReady), .lfValid(lfValid), .lfSel(lfSel),
      .lfReady(lfReady), .wr(wr), .regWr(regWr), .regRd(regRd),
      .regAddr(regAddr), .regWdata(regWdata), .secure(secure), .priv(priv),
      .regRdata(regRdata), .regRvalid(regRvalid), .regErr(regErr),
      .ramEn(ramEn), .ramReq(ramReq), .ramRdata(ramRdata));
   sbcd_partner sbcd_partner_i (.clk(clk), .rst(rst), .stall(stall),
      .hit(hit), .lkValid(lkValid), .lkDone(lkDone), .lkHit(lkHit),
      .cwValid(cwValid), .cwReady(cwReady), .awValid(awValid),
      .awReady(awReady), .lfValid(lfValid), .lfReady(lfReady),
      .ramEn(ramEn), .ramReq(ramReq), .ramRdata(ramRdata));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      if (awValid && awReady) outQ.push_back({2'h0, wr});
      if (cwValid && cwReady) outQ.push_back({2'h1, wr});
      if (lfValid && lfReady[lfSel]) outQ.push_back({2'h2, wr});
   end

   task automatic printVerdict();
      if (nMismatch == 0 && checksDone > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic hung();
      nMismatch++;
      printVerdict();
   endtask
   function automatic sbcd_attr_s at(logic dv, c, wa, rl, logic [2:0] o);
      return '{dv, c, wa, 1'b1, 1'b0, rl, 1'b0, o};
   endfunction
   task automatic put(input logic [31:0] a, input logic [63:0] d,
         input logic [7:0] s, input sbcd_attr_s t);
      int n;
      st <= '{a, d, s, t};
      stValid <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (stReady !== 1'b1 && n < 300);
      if (n >= 300) hung();
      stValid <= 1'b0;
      @(posedge clk);
   endtask
   task automatic waitN(input int k);
      int n;
      n = 0;
      while (outQ.size() < k && n < 300) begin @(posedge clk); n++; end
      if (n >= 300) hung();
   endtask
   task automatic expOut(input logic [1:0] k, input logic [31:0] a,
         input logic [63:0] d, input logic [7:0] s, input logic [2:0] sa);
      logic [WRW+1:0] e;
      sbcd_wr_s w;
      logic [63:0] m;
      waitN(1);
      e = outQ.pop_front();
      w = e[WRW-1:0];
      for (int i = 0; i < 8; i++) m[i*8 +: 8] = {8{s[i]}};
      `CHK("kind", k, e[WRW+1 -: 2])
      `CHK("addr", a[31:3], w.addr[31:3])
      `CHK("strb", s, w.strb)
      `CHK("data", d & m, w.data & m)
      if (k == 2'h1) `CHK("status", sa, w.status)
   endtask
   task automatic wrReg(input logic [31:0] a, input logic [31:0] v);
      regAddr <= a;
      regWdata <= v;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rdReg(input logic [31:0] a, output logic [31:0] d,
         output logic e);
      int n;
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      n = 0;
      do begin @(posedge clk); n++; end while (regRvalid !== 1'b1 && n < 8);
      if (n >= 8) hung();
      d = regRdata;
      e = regErr;
   endtask

   initial begin
      logic [31:0] d;
      logic e;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      @(posedge clk);
      `CHK("empty", 1'b1, sbEmpty)
      `CHK("rdata", 32'h0, regRdata)
      rdReg(ICLR_ADDR, d, e);
      `CHK("locreset", 32'h0, d)
      foreach (rows[i]) begin
         wrReg(rows[i][64] ? DCLR_ADDR : ICLR_ADDR, rows[i][63:32]);
         rdReg(rows[i][64] ? DCRR_ADDR : ICRR_ADDR, d, e);
         `CHK("ramword", rows[i][31:0], d)
         `CHK("err", 1'b0, e)
         rdReg(rows[i][64] ? DCLR_ADDR : ICLR_ADDR, d, e);
         `CHK("loc", rows[i][63:32], d)
      end
      for (int i = 0; i < 2; i++) begin
         {secure, priv} <= i ? 2'b01 : 2'b10;
         wrReg(ICLR_ADDR, 32'h1);
         rdReg(ICRR_ADDR, d, e);
         `CHK("deniederr", 1'b1, e)
         `CHK("denieddata", 32'h0, d)
      end
      {secure, priv} <= 2'b11;
      rdReg(ICLR_ADDR, d, e);
      `CHK("lockept", 32'h23, d)
      rdReg(32'he001e208, d, e);
      `CHK("unmapped", 1'b1, e)
      `CHK("unmappeddata", 32'h0, d)
      // merge of two halves, then two device stores that never merge
      put(32'h2000_0000, 64'h1111_2222_3333_4444, 8'h0f, at(0, 0, 0, 0, 0));
      put(32'h2000_0004, 64'h5555_6666_7777_8888, 8'hf0, at(0, 0, 0, 0, 0));
      put(32'h2100_0000, 64'h1, 8'h0f, at(1, 0, 0, 0, 0));
      put(32'h2100_0004, 64'h2, 8'hf0, at(1, 0, 0, 0, 0));
      expOut(0, 32'h2000_0000, 64'h5555_6666_3333_4444, 8'hff, 0);
      expOut(0, 32'h2100_0000, 64'h1, 8'h0f, 0);
      expOut(0, 32'h2100_0004, 64'h2, 8'hf0, 0);
      put(32'h2200_0000, 64'h1, 8'h0f, at(0, 0, 0, 0, 0));
      put(32'h2200_0004, 64'h2, 8'hf0, 10'h060);
      expOut(0, 32'h2200_0000, 64'h1, 8'h0f, 0);
      expOut(0, 32'h2200_0004, 64'h2, 8'hf0, 0);
      for (int o = 0; o < 8; o++)
         put(32'h1000_0000 + o * 8, 64'h9 + o, 8'hff, at(0, 1, 0, 0, o));
      for (int o = 0; o < 8; o++)
         expOut(1, 32'h1000_0000 + o * 8, 64'h9 + o, 8'hff,
            o > 4 ? 3'h6 : 3'(o + 2));
      hit <= 1'b0;
      put(32'h4000_0000, 64'h5, 8'hff, at(0, 1, 1, 0, 0));
      put(32'h4000_0008, 64'h6, 8'hff, at(0, 1, 0, 0, 0));
      expOut(2, 32'h4000_0000, 64'h5, 8'hff, 0);
      expOut(0, 32'h4000_0008, 64'h6, 8'hff, 0);
      for (int t = 0; t < 3; t++) begin
         put(32'h3000_0000 + t * 8, 64'h7, 8'hff, at(0, 0, 0, 0, 0));
         {cmoPending, barrierReq, debugEvent} <= 3'h4 >> t;
         repeat (8) @(posedge clk);
         `CHK("drain", 1, outQ.size())
         {cmoPending, barrierReq, debugEvent} <= 3'h0;
         expOut(0, 32'h3000_0000 + t * 8, 64'h7, 8'hff, 0);
      end
      // held AXI side: full buffer refuses, device store blocks loads
      stall <= 1'b1;
      for (int i = 0; i < 5; i++)
         put(32'h5000_0000 + i * 8, 64'h3, 8'hff, at(0, 0, 0, 0, 0));
      st <= '{32'h5000_0028, 64'h3, 8'hff, at(0, 0, 0, 0, 0)};
      stValid <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK("fullstall", 1'b0, stReady)
      stall <= 1'b0;
      put(32'h5000_0028, 64'h3, 8'hff, at(0, 0, 0, 0, 0));
      for (int i = 0; i < 6; i++)
         expOut(0, 32'h5000_0000 + i * 8, 64'h3, 8'hff, 0);
      stall <= 1'b1;
      put(32'h6000_0000, 64'h4, 8'hff, at(1, 0, 0, 0, 0));
      devLoadReq <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK("devload", 1'b0, devLoadGo)
      stall <= 1'b0;
      expOut(0, 32'h6000_0000, 64'h4, 8'hff, 0);
      repeat (3) @(posedge clk);
      `CHK("devloadgo", 1'b1, devLoadGo)
      devLoadReq <= 1'b0;
      acqPending <= 1'b1;
      st <= '{32'h7000_0000, 64'h8, 8'hff, at(0, 0, 0, 0, 0)};
      stValid <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK("acquire", 1'b0, stReady)
      acqPending <= 1'b0;
      put(32'h7000_0000, 64'h8, 8'hff, at(0, 0, 0, 0, 0));
      st <= '{32'h7000_0000, 64'h9, 8'hff, at(0, 0, 0, 1, 0)};
      stValid <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK("release", 1'b0, stReady)
      put(32'h7000_0000, 64'h9, 8'hff, at(0, 0, 0, 1, 0));
      expOut(0, 32'h7000_0000, 64'h8, 8'hff, 0);
      expOut(0, 32'h7000_0000, 64'h9, 8'hff, 0);
      st <= '{32'h7100_0000, 64'h1, 8'hff, 10'h8};
      stValid <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK("bypass", 1'b1, bypassValid)
      `CHK("bypassempty", 1'b1, sbEmpty)
      stValid <= 1'b0;
      printVerdict();
   end
endmodule
`default_nettype wire
